// File: rtl/sgs_pkg.sv
package sgs_pkg;
   // ==========================================================
   // timing
   localparam int CLK_HZ          = 25000000;
   localparam int LOCK_TIMEOUT_MS = 600;
   localparam int MIN_LOW_MS      = 500;
   localparam int LOCK_TIMEOUT_CYC = (CLK_HZ / 1000) * LOCK_TIMEOUT_MS;
   localparam int MIN_LOW_CYC      = (CLK_HZ / 1000) * MIN_LOW_MS;
   localparam int CNT_W            = 24;
   // ==========================================================
   // power-up holding test
   localparam int RETRY_MAX = 7;
   localparam int RETRY_W   = 4;
   // ==========================================================
   // synchroniser
   localparam int SYNC_STAGES = 3;

   typedef enum logic [1:0] {
      SGS_MAG_IDLE = 2'b00,
      SGS_MAG_WAIT = 2'b01,
      SGS_MAG_HELD = 2'b10,
      SGS_MAG_FAIL = 2'b11
   } sgs_mag_t;
endpackage

// File: rtl/sgs_sync.sv
`timescale 1ns/10ps
module sgs_sync #(
   parameter int WIDTH = 5
) (
   input  wire logic             clk,
   input  wire logic             nrst,
   input  wire logic [WIDTH-1:0] din,
   output logic      [WIDTH-1:0] dout
);
   // ==========================================================
   // three stages; a change counts once stages two and three agree
   logic [WIDTH-1:0] s1_r;
   logic [WIDTH-1:0] s2_r;
   logic [WIDTH-1:0] s3_r;
   logic [WIDTH-1:0] out_r;

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         s1_r <= '0;
         s2_r <= '0;
         s3_r <= '0;
      end else begin
         s1_r <= din;
         s2_r <= s1_r;
         s3_r <= s2_r;
      end
   end

   genvar i;
   generate
      for (i = 0; i < WIDTH; i++) begin : g_bit
         always_ff @(posedge clk or negedge nrst) begin
            if (!nrst) begin
               out_r[i] <= 1'b0;
            end else if (s2_r[i] == s3_r[i]) begin
               out_r[i] <= s3_r[i];
            end
         end
      end
   endgenerate

   assign dout = out_r;
endmodule // sgs_sync

// File: rtl/sgs_gate_logic.sv
`timescale 1ns/10ps
// Functional notes
// [R01] outputs high only when all conditions hold
// [R02] outputs low on any failing condition
// [R03] lock status high while actuator present
// [R04] status held if force reached or unlocked
// [R05] status low on absence or force timeout
// [R06] recover after 500 ms low then high
// [R07] flag unequal inputs on single fall
// [R08] fallen input rising again locks outputs
// [R09] lock cleared once both inputs low
// [R10] magnet on with command and actuator; the code also holds it off in SGS_MAG_FAIL
// [R11] power-up force test blocks outputs
// [R12] seven silent retries, lock on success
// [R13] controller keeps command low 500 ms
// [R14] forced opening drops outputs at once
// [R15] evaluator treats outputs as two channels
// [R16] chained outputs feed next inputs
// [R17] lock failure on timeout or forcing
// [R18] partial operation shown during one-sided fall
// [R19] counters on one clock, reset clears
// [R20] external inputs synchronised first
module sgs_gate_logic #(
   parameter int LOCK_CYC = sgs_pkg::LOCK_TIMEOUT_CYC,
   parameter int LOW_CYC  = sgs_pkg::MIN_LOW_CYC
) (
   input  wire logic clk,
   input  wire logic nrst,
   input  wire logic actuatorPresent,
   input  wire logic channelOneInput,
   input  wire logic channelTwoInput,
   input  wire logic lockCommandInput,
   input  wire logic holdingForceOk,
   output logic      safetyOutOne,
   output logic      safetyOutTwo,
   output logic      lockStatusOutput,
   output logic      magnetEnable,
   output logic      unequalFlag,
   output logic      plausError,
   output logic      lockFailure
);
   // ==========================================================
   // input synchronisation
   logic [4:0] syncIn;
   logic       act;
   logic       ch1;
   logic       ch2;
   logic       cmd;
   logic       holdOk;

   sgs_sync #(.WIDTH(5)) u_sync ( // [R20]
      .clk  (clk),
      .nrst (nrst),
      .din  ({actuatorPresent, channelOneInput, channelTwoInput,
              lockCommandInput, holdingForceOk}),
      .dout (syncIn)
   );
   assign {act, ch1, ch2, cmd, holdOk} = syncIn;

   logic ch1Prev_r;
   logic ch2Prev_r;
   logic cmdPrev_r;
   logic actPrev_r;
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         ch1Prev_r <= 1'b0;
         ch2Prev_r <= 1'b0;
         cmdPrev_r <= 1'b0;
         actPrev_r <= 1'b0;
      end else begin
         ch1Prev_r <= ch1;
         ch2Prev_r <= ch2;
         cmdPrev_r <= cmd;
         actPrev_r <= act;
      end
   end

   // ==========================================================
   // plausibility monitoring
   logic unequal_r;
   logic partLock_r;
   logic oneFall;
   logic reRise;
   assign oneFall = (ch1Prev_r & ~ch1 & ch2) | (ch2Prev_r & ~ch2 & ch1);
   assign reRise  = unequal_r & ((~ch1Prev_r & ch1 & ch2) | (~ch2Prev_r & ch2 & ch1));

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         unequal_r  <= 1'b0;
         partLock_r <= 1'b0;
      end else begin
         if (!ch1 && !ch2) begin
            unequal_r  <= 1'b0; // [R09]
            partLock_r <= 1'b0; // [R09]
         end else begin
            if (oneFall) begin
               unequal_r <= 1'b1; // [R07]
            end
            if (reRise) begin
               partLock_r <= 1'b1; // [R08]
            end
         end
      end
   end

   // ==========================================================
   // magnet control and holding-force monitor
   sgs_pkg::sgs_mag_t           magState_r;
   logic [sgs_pkg::CNT_W-1:0]   lockCnt_r;
   logic [sgs_pkg::CNT_W-1:0]   lowCnt_r;
   logic [sgs_pkg::RETRY_W-1:0] retry_r;
   logic                        powerTest_r;
   logic                        lowLongEnough_r;
   logic                        forcedOpen_r;
   logic                        magOn;
   logic                        forcedEvt;

   assign magOn     = cmd & act; // [R10]
   // actuator lost while the magnet held the gate
   assign forcedEvt = actPrev_r & ~act & (magState_r == sgs_pkg::SGS_MAG_HELD);

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         lowCnt_r        <= '0;
         lowLongEnough_r <= 1'b0;
      end else if (cmd) begin
         lowCnt_r        <= '0;
         // a short low after an earlier long one must not count again
         lowLongEnough_r <= 1'b0; // [R06]
      end else if (lowCnt_r >= sgs_pkg::CNT_W'(LOW_CYC - 1)) begin
         lowLongEnough_r <= 1'b1; // [R06]
      end else begin
         lowCnt_r <= lowCnt_r + 1'b1; // [R19]
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         magState_r   <= sgs_pkg::SGS_MAG_IDLE;
         lockCnt_r    <= '0;
         retry_r      <= '0;
         powerTest_r  <= 1'b1; // [R11]
         forcedOpen_r <= 1'b0;
      end else begin
         if (forcedEvt) begin
            forcedOpen_r <= 1'b1; // [R14]
         end else if (!cmd) begin
            forcedOpen_r <= 1'b0;
         end
         case (magState_r)
            sgs_pkg::SGS_MAG_IDLE: begin
               lockCnt_r <= '0;
               if (magOn) begin
                  magState_r <= sgs_pkg::SGS_MAG_WAIT;
               end
            end
            sgs_pkg::SGS_MAG_WAIT: begin
               if (!magOn) begin
                  magState_r <= sgs_pkg::SGS_MAG_IDLE;
               end else if (holdOk) begin
                  magState_r  <= sgs_pkg::SGS_MAG_HELD;
                  powerTest_r <= 1'b0; // [R12]
               end else if (lockCnt_r >= sgs_pkg::CNT_W'(LOCK_CYC - 1)) begin
                  lockCnt_r <= '0;
                  if (powerTest_r && retry_r < sgs_pkg::RETRY_W'(sgs_pkg::RETRY_MAX)) begin
                     retry_r <= retry_r + 1'b1; // [R12]
                  end else begin
                     powerTest_r <= 1'b0;
                     magState_r  <= sgs_pkg::SGS_MAG_FAIL; // [R05]
                  end
               end else begin
                  lockCnt_r <= lockCnt_r + 1'b1; // [R19]
               end
            end
            sgs_pkg::SGS_MAG_HELD: begin
               if (!magOn) begin
                  magState_r <= sgs_pkg::SGS_MAG_IDLE;
               end
            end
            sgs_pkg::SGS_MAG_FAIL: begin
               // leave only after a long enough low then a new rise
               if (cmd && !cmdPrev_r && lowLongEnough_r) begin
                  magState_r <= sgs_pkg::SGS_MAG_IDLE; // [R06]
               end
            end
            default: begin
               magState_r <= sgs_pkg::SGS_MAG_IDLE;
            end
         endcase
      end
   end

   // ==========================================================
   // outputs, all registered
   logic safeOk;
   logic statusNxt;
   assign safeOk = act & ch1 & ch2 & cmd & (magState_r == sgs_pkg::SGS_MAG_HELD)
                 & ~partLock_r & ~powerTest_r & ~forcedEvt & ~forcedOpen_r // [R01] [R02]
                 // the re-rise cycle itself must not pulse the outputs
                 & ~reRise; // [R08]
   // power-up retries keep the status output untouched
   assign statusNxt = act & (magState_r != sgs_pkg::SGS_MAG_FAIL); // [R03] [R04] [R05]

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         safetyOutOne     <= 1'b0;
         safetyOutTwo     <= 1'b0;
         lockStatusOutput <= 1'b0;
         magnetEnable     <= 1'b0;
         unequalFlag      <= 1'b0;
         plausError       <= 1'b0;
         lockFailure      <= 1'b0;
      end else begin
         safetyOutOne     <= safeOk; // [R01] [R14] [R16]
         safetyOutTwo     <= safeOk; // [R01] [R14] [R16]
         lockStatusOutput <= statusNxt; // [R03]
         magnetEnable     <= magOn & (magState_r != sgs_pkg::SGS_MAG_FAIL); // [R10]
         unequalFlag      <= unequal_r & ~partLock_r; // [R18]
         plausError       <= partLock_r; // [R08]
         lockFailure      <= (magState_r == sgs_pkg::SGS_MAG_FAIL) | forcedOpen_r; // [R17]
      end
   end

   // ==========================================================
   // checks
   AST_SAFE_NEEDS_ALL: assert property (@(posedge clk) disable iff (!nrst)
      safetyOutOne |-> $past(act) && $past(ch1) && $past(ch2) && $past(cmd)) // [R01]
      else $error("safety output high without all conditions");
   AST_SAFE_LOW_ON_CH: assert property (@(posedge clk) disable iff (!nrst)
      (!ch1 || !ch2) |=> !safetyOutTwo) // [R02]
      else $error("safety output high with a channel low");
   AST_STATUS_ACT: assert property (@(posedge clk) disable iff (!nrst)
      !act |=> !lockStatusOutput) // [R05]
      else $error("status high with actuator absent");
   AST_STATUS_HIGH: assert property (@(posedge clk) disable iff (!nrst)
      (act && magState_r != sgs_pkg::SGS_MAG_FAIL) |=> lockStatusOutput) // [R03]
      else $error("status low with actuator present");
   AST_PLAUS_CLEAR: assert property (@(posedge clk) disable iff (!nrst)
      (!ch1 && !ch2) |=> !partLock_r ##1 !plausError) // [R09]
      else $error("partial lock not cleared");
   AST_PLAUS_OFF: assert property (@(posedge clk) disable iff (!nrst)
      partLock_r |=> !safetyOutOne) // [R08]
      else $error("outputs on during partial lock");
   AST_RERISE_OFF: assert property (@(posedge clk) disable iff (!nrst)
      reRise |=> !safetyOutOne && !safetyOutTwo) // [R08]
      else $error("outputs on at channel re-rise");
   AST_MAGNET: assert property (@(posedge clk) disable iff (!nrst)
      (cmd && act && magState_r != sgs_pkg::SGS_MAG_FAIL) |=> magnetEnable) // [R10]
      else $error("magnet not energised");
   AST_FORCED: assert property (@(posedge clk) disable iff (!nrst)
      forcedEvt |=> !safetyOutOne && !safetyOutTwo ##1 lockFailure) // [R14]
      else $error("forced opening not handled");
   AST_FAIL_EXIT: assert property (@(posedge clk) disable iff (!nrst)
      (magState_r == sgs_pkg::SGS_MAG_FAIL && !lowLongEnough_r)
      |=> magState_r == sgs_pkg::SGS_MAG_FAIL) // [R06]
      else $error("failure left without long low");
endmodule // sgs_gate_logic

// File: dv/sgs_eval_model.sv
`timescale 1ns/10ps
// ====================================
// evaluator standing at the far side
module sgs_eval_model (
   input  wire logic clk,
   input  wire logic nrst,
   input  wire logic chOne,
   input  wire logic chTwo,
   output logic      relayOn,
   output logic      crossFault
);
   logic chOne_r;
   logic chTwo_r;
   // each channel latched on its own so one stuck line cannot mask the other
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         chOne_r <= 1'b0;
         chTwo_r <= 1'b0;
      end else begin
         chOne_r <= chOne;
         chTwo_r <= chTwo;
      end
   end
   assign relayOn    = chOne_r & chTwo_r;
   assign crossFault = chOne_r ^ chTwo_r;
endmodule // sgs_eval_model

// File: dv/test_sgs_gate_logic.sv
`timescale 1ns/10ps
module test_sgs_gate_logic;
   typedef struct {logic [4:0] in; int w; logic [3:0] ex;} sgs_row_t;
   logic clk, nrst, act, c1, c2, cmd, frc;
   logic so1, so2, st, mag, uneq, pErr, lFail, relayOn, crossFault;
   int   err_count, n_checks, cycles;
   // in = {act,ch1,ch2,cmd,force}, ex = {safe,status,magnet,lockfail}
   sgs_row_t rows [8] = '{'{5'h1f, 12, 4'he}, '{5'h13, 8, 4'h6}, '{5'h1f, 8, 4'he},
      '{5'h1d, 20, 4'h4}, '{5'h1f, 8, 4'he}, '{5'h0f, 8, 4'h1}, '{5'h1d, 20, 4'h4},
      '{5'h1f, 8, 4'he}};

   sgs_gate_logic #(.LOCK_CYC(20), .LOW_CYC(15)) sgs_gate_logic_i (
      .clk(clk), .nrst(nrst), .actuatorPresent(act), .channelOneInput(c1),
      .channelTwoInput(c2), .lockCommandInput(cmd), .holdingForceOk(frc),
      .safetyOutOne(so1), .safetyOutTwo(so2), .lockStatusOutput(st),
      .magnetEnable(mag), .unequalFlag(uneq), .plausError(pErr), .lockFailure(lFail));
   sgs_eval_model sgs_eval_model_i (.clk(clk), .nrst(nrst), .chOne(so1), .chTwo(so2),
      .relayOn(relayOn), .crossFault(crossFault));

   // ====================================
   // clock and watchdog
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   always @(posedge clk) begin
      cycles++;
      if (cycles == 5000) begin
         err_count++;
         give_verdict();
      end
   end

   // ====================================
   // tasks
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   task automatic chk(input logic got, input logic exp, input string m);
      n_checks++;
      if (got !== exp) begin
         err_count++;
         $display("MISMATCH t=%0t %s", $time, m);
      end
   endtask
   // inputs move 2 ns after the edge, then n edges pass
   task automatic step(input logic [4:0] v, input int n);
      {act, c1, c2, cmd, frc} = v;
      repeat (n) @(posedge clk);
      #2;
   endtask
   task automatic rst(input logic [4:0] v);
      nrst = 1'b0;
      step(v, 3);
      nrst = 1'b1;
   endtask

   // ====================================
   // sequence
   initial begin
      {nrst, act, c1, c2, cmd, frc} = 6'h00;
      err_count = 0;
      n_checks = 0;
      cycles = 0;
      rst(5'h1f);
      for (int i = 0; i < 8; i++) begin
         step(rows[i].in, rows[i].w);
         chk(so1, rows[i].ex[3], "safe one");
         chk(so2, rows[i].ex[3], "safe two");
         chk(relayOn, rows[i].ex[3], "relay");
         chk(crossFault, 1'b0, "cross");
         chk(st, rows[i].ex[2], "status");
         chk(mag, rows[i].ex[1], "magnet");
         chk(lFail, rows[i].ex[0], "lock fail");
      end
      $display("test rows done");
      step(5'h17, 8);
      chk(uneq, 1'b1, "unequal");
      chk(so1, 1'b0, "safe low");
      step(5'h1f, 8);
      chk(pErr, 1'b1, "plaus");
      chk(so1, 1'b0, "partial lock");
      chk(so2, 1'b0, "partial lock");
      step(5'h13, 8);
      chk(pErr, 1'b0, "plaus clear");
      chk(uneq, 1'b0, "unequal clear");
      step(5'h1f, 8);
      chk(so1, 1'b1, "safe back");
      $display("test plausibility done");
      step(5'h1d, 20);
      step(5'h1e, 40);
      chk(st, 1'b0, "status timeout");
      chk(lFail, 1'b1, "lock fail");
      chk(so1, 1'b0, "safe timeout");
      step(5'h1c, 6);
      step(5'h1e, 10);
      chk(st, 1'b0, "short low refused");
      chk(lFail, 1'b1, "fail kept");
      step(5'h1d, 20);
      step(5'h1f, 8);
      chk(st, 1'b1, "status recover");
      chk(lFail, 1'b0, "lock fail clear");
      chk(so1, 1'b1, "safe recover");
      $display("test timeout done");
      rst(5'h1e);
      step(5'h1e, 135);
      chk(so1, 1'b0, "safe in test");
      chk(st, 1'b1, "status in retry");
      chk(lFail, 1'b0, "no fail yet");
      step(5'h1f, 10);
      chk(so1, 1'b1, "late success");
      rst(5'h1e);
      step(5'h1e, 150);
      chk(st, 1'b1, "retries left");
      step(5'h1e, 60);
      chk(st, 1'b0, "all retries used");
      chk(lFail, 1'b1, "power-up fail");
      chk(so1, 1'b0, "safe stays low");
      $display("test power-up done");
      give_verdict();
   end
endmodule // test_sgs_gate_logic
